//--- design/tmr_pkg.sv
// Purpose: constants and carrier types for the 16-bit timer block
// Assumes: 8-bit I/O register space, a single clock
// Notes:   offsets are I/O offsets; data space adds a fixed bias
package tmr_pkg;
  localparam logic [5:0] OFS_CAP_LO   = 6'h26;
  localparam logic [5:0] OFS_CAP_HI   = 6'h27;
  localparam logic [5:0] OFS_CMPB_LO  = 6'h28;
  localparam logic [5:0] OFS_CMPA_LO  = 6'h2a;
  localparam logic [5:0] OFS_CNT_LO   = 6'h2c;
  localparam logic [5:0] OFS_CNT_HI   = 6'h2d;
  localparam logic [5:0] OFS_CTRL_B   = 6'h2e;
  localparam logic [5:0] OFS_CTRL_A   = 6'h2f;
  localparam logic [6:0] IO_SPACE_END = 7'h40;
  localparam logic [6:0] DATA_BIAS    = 7'h20;

  localparam logic [7:0]  CTRL_A_RST   = 8'h00;
  localparam logic [7:0]  CTRL_B_RST   = 8'h00;
  localparam logic [15:0] REG16_RST    = 16'h0000;
  // Force strobes and the unused bit are never stored
  localparam logic [7:0]  CTRL_A_WMASK = 8'hf3;
  localparam logic [7:0]  CTRL_B_WMASK = 8'hdf;

  localparam int CB_FILT  = 7;
  localparam int CB_EDGE  = 6;
  localparam int CB_WM_HI = 4;
  localparam int CB_CS_HI = 2;
  localparam int CA_WM_HI = 1;

  localparam logic [3:0] MODE_NORMAL   = 4'h0;
  localparam logic [3:0] MODE_PC8      = 4'h1;
  localparam logic [3:0] MODE_PC9      = 4'h2;
  localparam logic [3:0] MODE_PC10     = 4'h3;
  localparam logic [3:0] MODE_CTC_CMP  = 4'h4;
  localparam logic [3:0] MODE_FAST8    = 4'h5;
  localparam logic [3:0] MODE_FAST9    = 4'h6;
  localparam logic [3:0] MODE_FAST10   = 4'h7;
  localparam logic [3:0] MODE_PFC_CAP  = 4'h8;
  localparam logic [3:0] MODE_PFC_CMP  = 4'h9;
  localparam logic [3:0] MODE_PC_CAP   = 4'ha;
  localparam logic [3:0] MODE_PC_CMP   = 4'hb;
  localparam logic [3:0] MODE_CTC_CAP  = 4'hc;
  localparam logic [3:0] MODE_RSVD     = 4'hd;
  localparam logic [3:0] MODE_FAST_CAP = 4'he;
  localparam logic [3:0] MODE_FAST_CMP = 4'hf;

  localparam logic [15:0] TOP_8   = 16'h00ff;
  localparam logic [15:0] TOP_9   = 16'h01ff;
  localparam logic [15:0] TOP_10  = 16'h03ff;
  localparam logic [15:0] TOP_MAX = 16'hffff;
  localparam logic [15:0] BOTTOM  = 16'h0000;

  localparam logic [2:0] CS_STOP     = 3'h0;
  localparam logic [2:0] CS_DIV1     = 3'h1;
  localparam logic [2:0] CS_DIV8     = 3'h2;
  localparam logic [2:0] CS_DIV64    = 3'h3;
  localparam logic [2:0] CS_DIV256   = 3'h4;
  localparam logic [2:0] CS_DIV1024  = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  localparam int          PRESCALE_W   = 10;
  localparam logic [9:0]  DIV8_MASK    = 10'h007;
  localparam logic [9:0]  DIV64_MASK   = 10'h03f;
  localparam logic [9:0]  DIV256_MASK  = 10'h0ff;
  localparam logic [9:0]  DIV1024_MASK = 10'h3ff;
  localparam logic [9:0]  PRESCALE_RST = 10'h000;

  localparam int FILTER_SAMPLES = 4;

  typedef struct packed {
    logic [6:0] addr;
    logic       data_space;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } io_req_t;
endpackage

//--- design/pin_cond.sv
// Purpose: synchronise a pin, optionally filter it, flag the chosen edge
// Assumes: pin_i is asynchronous to mclk_i
// Notes:   edge_o is a one-cycle pulse, about six cycles after the pin, or ten with filtering on
module pin_cond #(
  parameter int unsigned FILT_LEN = tmr_pkg::FILTER_SAMPLES
) (
  input  wire logic mclk_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  input  wire logic filt_en_i,
  input  wire logic rise_sel_i,
  output logic      edge_o
);
  logic [2:0]          sync_r;
  logic                lvl_r;
  logic [FILT_LEN-1:0] hist_r;
  logic                filt_r;
  logic                prev_r;
  logic                edge_r;

  wire logic all_hi   = &hist_r;
  wire logic all_lo   = ~|hist_r;
  // when filtering, output moves only on a full run of equal samples
  wire logic filt_nxt = !filt_en_i ? lvl_r : all_hi ? 1'b1 : all_lo ? 1'b0 : filt_r;
  // edge chosen by the select input
  wire logic edge_nxt = rise_sel_i ? (filt_r & ~prev_r) : (~filt_r & prev_r);

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sync_r <= 3'h0;
      lvl_r  <= 1'b0;
      hist_r <= '0;
      filt_r <= 1'b0;
      prev_r <= 1'b0;
      edge_r <= 1'b0;
    end else begin
      sync_r <= {sync_r[1:0], pin_i};
      // A change counts once the last two stages agree
      if (sync_r[1] == sync_r[2]) begin
        lvl_r <= sync_r[2];
      end
      hist_r <= {hist_r[FILT_LEN-2:0], lvl_r};
      filt_r <= filt_nxt;
      prev_r <= filt_r;
      edge_r <= edge_nxt;
    end
  end

  assign edge_o = edge_r;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  filt_hold_a: assert property (filt_en_i && !all_hi && !all_lo |=> filt_r == $past(filt_r))
    else $error("filtered level moved without a full run");
  edge_dir_a: assert property (edge_o |-> prev_r == $past(rise_sel_i, 2) || $past(rise_sel_i) != $past(rise_sel_i, 2))
    else $error("edge pulse does not match selected polarity");
  filt_cov_c: cover property (filt_en_i && all_hi && !filt_r ##1 filt_r);
endmodule

//--- design/timer16_mode_clock_capture.sv
// Purpose: mode, clock select and input capture of a 16-bit timer
// Assumes: CPU reaches registers over the 8-bit I/O space, one clock
// Notes:   read data is registered and appears one cycle after rd

// Functional notes
// - Four-bit mode from both control registers
// - Normal: top all ones, flag at max
// - Clear-on-match: top compare A or capture
// - Phase correct: up-down, update top, flag bottom
// - Fast: count up, update bottom, flag top
// - Phase-frequency: update and flag at bottom
// - Filter needs four equal samples
// - Edge select: zero falling, one rising
// - Capture copies counter, sets capture flag
// - Capture-as-top disables capture input
// - Clock select: stop or divided clock
// - Selects six/seven count external pin edges
// - External pin counts even when driven
// - Sixteen-bit access through shared high byte
// - Counter write blocks next compare match
// - I/O offsets, data space adds bias
module timer16_mode_clock_capture (
  input  wire logic             mclk_i,
  input  wire logic             rst_i,
  input  wire tmr_pkg::io_req_t io_req_i,
  input  wire logic             capture_input_pin_i,
  input  wire logic             external_count_pin_i,
  input  wire logic             ovf_clear_i,
  input  wire logic             cap_clear_i,
  output logic [7:0]            io_rdata_o,
  output logic [15:0]           counter_value_o,
  output logic                  overflow_flag_o,
  output logic                  capture_flag_o,
  output logic [1:0]            compare_match_o,
  output logic                  count_down_o
);
  logic [7:0]                     ctrl_a_r;
  logic [7:0]                     ctrl_b_r;
  logic [7:0]                     temp_r;
  logic [15:0]                    cnt_r;
  logic [15:0]                    cnt_nxt;
  logic                           dir_r;
  logic                           dir_nxt;
  logic [tmr_pkg::PRESCALE_W-1:0] pre_r;
  logic                           blk_r;
  logic [15:0]                    capture_register_r;
  logic                           ovf_r;
  logic                           capf_r;
  logic [1:0]                     match_r;
  logic [1:0]                     match;
  logic [1:0]                     wr_ocr;
  logic [7:0]                     rdata_r;
  logic                           ext_edge;
  logic                           cap_edge;

  // I/O offset or data-space address less the bias
  wire logic       ds       = io_req_i.data_space;
  wire logic [6:0] rel      = ds ? io_req_i.addr - tmr_pkg::DATA_BIAS : io_req_i.addr;
  wire logic       in_range = rel < tmr_pkg::IO_SPACE_END && (!ds || io_req_i.addr >= tmr_pkg::DATA_BIAS);
  wire logic [5:0] ofs      = rel[5:0];
  wire logic       wr       = io_req_i.wr && in_range;
  wire logic       rd       = io_req_i.rd && in_range;
  wire logic [7:0] wdata    = io_req_i.wdata;

  wire logic wide    = ofs >= tmr_pkg::OFS_CAP_LO && ofs <= tmr_pkg::OFS_CNT_HI;
  wire logic wr16    = wr && wide && !ofs[0];
  wire logic wr_temp = wr && wide && ofs[0];
  wire logic rd_lo   = rd && wide && !ofs[0];
  // low-byte write joins the shared high byte
  wire logic [15:0] wdata16 = {temp_r, wdata};
  wire logic wr_cnt  = wr16 && ofs == tmr_pkg::OFS_CNT_LO;
  wire logic wr_cap  = wr16 && ofs == tmr_pkg::OFS_CAP_LO;

  // mode from control B high pair and control A low pair
  wire logic [3:0] mode = {ctrl_b_r[tmr_pkg::CB_WM_HI -: 2], ctrl_a_r[tmr_pkg::CA_WM_HI -: 2]};
  wire logic rsv    = mode == tmr_pkg::MODE_RSVD;
  wire logic single = mode inside {tmr_pkg::MODE_NORMAL, tmr_pkg::MODE_CTC_CMP, tmr_pkg::MODE_CTC_CAP};
  wire logic fast   = mode inside {tmr_pkg::MODE_FAST8, tmr_pkg::MODE_FAST9, tmr_pkg::MODE_FAST10,
                                   tmr_pkg::MODE_FAST_CAP, tmr_pkg::MODE_FAST_CMP};
  wire logic pc     = mode inside {tmr_pkg::MODE_PC8, tmr_pkg::MODE_PC9, tmr_pkg::MODE_PC10,
                                   tmr_pkg::MODE_PC_CAP, tmr_pkg::MODE_PC_CMP};
  wire logic pfc    = mode inside {tmr_pkg::MODE_PFC_CAP, tmr_pkg::MODE_PFC_CMP};
  wire logic dual   = pc || pfc;

  // TOP from capture or compare A in the register-top modes
  wire logic top_is_cap = mode inside {tmr_pkg::MODE_PFC_CAP, tmr_pkg::MODE_PC_CAP,
                                       tmr_pkg::MODE_CTC_CAP, tmr_pkg::MODE_FAST_CAP};
  wire logic top_is_oca = mode inside {tmr_pkg::MODE_CTC_CMP, tmr_pkg::MODE_PFC_CMP,
                                       tmr_pkg::MODE_PC_CMP, tmr_pkg::MODE_FAST_CMP};
  // fixed 8, 9 and 10-bit tops share the low mode bits
  wire logic [15:0] fixed_top = mode[3]          ? tmr_pkg::TOP_MAX :
                                mode[1:0] == 2'h1 ? tmr_pkg::TOP_8   :
                                mode[1:0] == 2'h2 ? tmr_pkg::TOP_9   :
                                mode[1:0] == 2'h3 ? tmr_pkg::TOP_10  : tmr_pkg::TOP_MAX;
  wire logic [15:0] top_val = top_is_cap ? capture_register_r :
                              top_is_oca ? g_cmp[0].act_r : fixed_top;
  wire logic at_top = cnt_r == top_val;
  wire logic at_bot = cnt_r == tmr_pkg::BOTTOM;

  // stop, or one tick per 1, 8, 64, 256 or 1024 clocks
  wire logic [2:0] cs = ctrl_b_r[tmr_pkg::CB_CS_HI -: 3];
  wire logic pre_tick = cs == tmr_pkg::CS_DIV1 ||
    (cs == tmr_pkg::CS_DIV8    && (pre_r & tmr_pkg::DIV8_MASK)    == tmr_pkg::DIV8_MASK)   ||
    (cs == tmr_pkg::CS_DIV64   && (pre_r & tmr_pkg::DIV64_MASK)   == tmr_pkg::DIV64_MASK)  ||
    (cs == tmr_pkg::CS_DIV256  && (pre_r & tmr_pkg::DIV256_MASK)  == tmr_pkg::DIV256_MASK) ||
    (cs == tmr_pkg::CS_DIV1024 && (pre_r & tmr_pkg::DIV1024_MASK) == tmr_pkg::DIV1024_MASK);
  // external edges only in the two pin modes
  wire logic ext_sel  = cs == tmr_pkg::CS_EXT_FALL || cs == tmr_pkg::CS_EXT_RISE;
  wire logic tick     = pre_tick || (ext_sel && ext_edge);
  // A counter write owns the cycle; the reserved mode holds the count
  wire logic tick_live = tick && !wr_cnt && !rsv;

  // normal and clear modes flag at MAX, fast at TOP, dual at BOTTOM
  wire logic ovf_evt = tick_live && (single ? cnt_r == tmr_pkg::TOP_MAX :
                                     fast   ? at_top : dual && dir_r && at_bot);
  // fast loads at the wrap; phase correct at TOP; at BOTTOM
  wire logic load_evt = tick_live && (fast ? at_top : pc ? at_top && !dir_r :
                                      pfc && at_bot && dir_r);
  // capture pin ignored while capture is TOP
  wire logic cap_evt = cap_edge && !top_is_cap;

  // the pin is sampled whatever drives it
  pin_cond #(
    .FILT_LEN (tmr_pkg::FILTER_SAMPLES)
  ) u_ext (
    .mclk_i     (mclk_i),
    .rst_i      (rst_i),
    .pin_i      (external_count_pin_i),
    .filt_en_i  (1'b0),
    .rise_sel_i (cs == tmr_pkg::CS_EXT_RISE),
    .edge_o     (ext_edge)
  );

  pin_cond #(
    .FILT_LEN (tmr_pkg::FILTER_SAMPLES)
  ) u_cap (
    .mclk_i     (mclk_i),
    .rst_i      (rst_i),
    .pin_i      (capture_input_pin_i),
    .filt_en_i  (ctrl_b_r[tmr_pkg::CB_FILT]),
    .rise_sel_i (ctrl_b_r[tmr_pkg::CB_EDGE]),
    .edge_o     (cap_edge)
  );

  for (genvar ch = 0; ch < 2; ch++) begin : g_cmp
    logic [15:0] buf_r;
    logic [15:0] act_r;
    wire logic [5:0] lo_ofs = (ch == 0) ? tmr_pkg::OFS_CMPA_LO : tmr_pkg::OFS_CMPB_LO;
    assign wr_ocr[ch] = wr16 && ofs == lo_ofs;
    // no match while the post-write block stands
    assign match[ch]  = tick_live && !blk_r && cnt_r == act_r;
    always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
        buf_r <= tmr_pkg::REG16_RST;
        act_r <= tmr_pkg::REG16_RST;
      end else begin
        if (wr_ocr[ch]) begin
          buf_r <= wdata16;
        end
        // immediate update in the normal, clear-on-match and reserved modes
        if (wr_ocr[ch] && (single || rsv)) begin
          act_r <= wdata16;
        end else if (load_evt) begin
          act_r <= buf_r;
        end
      end
    end
  end

  always_comb begin
    cnt_nxt = cnt_r;
    dir_nxt = dir_r && dual;
    if (wr_cnt) begin
      cnt_nxt = wdata16;
    end else if (tick_live && dual) begin
      // turn at TOP going up and at BOTTOM going down
      if (!dir_r && at_top) begin
        dir_nxt = 1'b1;
        cnt_nxt = cnt_r - 16'h0001;
      end else if (dir_r && at_bot) begin
        dir_nxt = 1'b0;
        cnt_nxt = cnt_r + 16'h0001;
      end else begin
        cnt_nxt = dir_r ? cnt_r - 16'h0001 : cnt_r + 16'h0001;
      end
    end else if (tick_live) begin
      // single slope restarts from BOTTOM after TOP
      cnt_nxt = at_top ? tmr_pkg::BOTTOM : cnt_r + 16'h0001;
    end
  end

  wire logic [15:0] sel16 = ofs[5:1] == tmr_pkg::OFS_CNT_LO[5:1]  ? cnt_r :
                            ofs[5:1] == tmr_pkg::OFS_CMPA_LO[5:1] ? g_cmp[0].buf_r :
                            ofs[5:1] == tmr_pkg::OFS_CMPB_LO[5:1] ? g_cmp[1].buf_r : capture_register_r;
  wire logic mapped = wide || ofs == tmr_pkg::OFS_CTRL_A || ofs == tmr_pkg::OFS_CTRL_B;
  // bit five is never stored, so it reads zero
  wire logic [7:0] rd_val = ofs == tmr_pkg::OFS_CTRL_A ? ctrl_a_r :
                            ofs == tmr_pkg::OFS_CTRL_B ? ctrl_b_r :
                            wide && ofs[0]             ? temp_r   :
                            wide                       ? sel16[7:0] : 8'h00;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_a_r <= tmr_pkg::CTRL_A_RST;
      ctrl_b_r <= tmr_pkg::CTRL_B_RST;
      temp_r   <= 8'h00;
      rdata_r  <= 8'h00;
    end else begin
      if (wr && ofs == tmr_pkg::OFS_CTRL_A) begin
        ctrl_a_r <= wdata & tmr_pkg::CTRL_A_WMASK;
      end
      if (wr && ofs == tmr_pkg::OFS_CTRL_B) begin
        ctrl_b_r <= wdata & tmr_pkg::CTRL_B_WMASK;
      end
      // high byte parks in temp; low read latches the high half
      if (wr_temp) begin
        temp_r <= wdata;
      end else if (rd_lo) begin
        temp_r <= sel16[15:8];
      end
      if (io_req_i.rd) begin
        rdata_r <= rd ? rd_val : 8'h00;
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r   <= tmr_pkg::REG16_RST;
      dir_r   <= 1'b0;
      pre_r   <= tmr_pkg::PRESCALE_RST;
      blk_r   <= 1'b0;
      match_r <= 2'h0;
    end else begin
      cnt_r   <= cnt_nxt;
      dir_r   <= dir_nxt;
      pre_r   <= pre_r + 10'h001;
      // block lasts until the next timer clock
      blk_r   <= wr_cnt || (blk_r && !tick);
      match_r <= match;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      capture_register_r <= tmr_pkg::REG16_RST;
      ovf_r              <= 1'b0;
      capf_r             <= 1'b0;
    end else begin
      // a capture beats a CPU write in the same cycle
      if (cap_evt) begin
        capture_register_r <= cnt_r;
      end else if (wr_cap) begin
        capture_register_r <= wdata16;
      end
      // Set beats clear so no event is lost
      ovf_r  <= ovf_evt || (ovf_r && !ovf_clear_i);
      capf_r <= cap_evt || (capf_r && !cap_clear_i);
    end
  end

  assign io_rdata_o      = rdata_r;
  assign counter_value_o = cnt_r;
  assign overflow_flag_o = ovf_r;
  assign capture_flag_o  = capf_r;
  assign compare_match_o = match_r;
  assign count_down_o    = dir_r;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  rsv_hold_a: assert property (rsv && !wr_cnt |=> cnt_r == $past(cnt_r))
    else $error("counter moved in reserved mode");
  norm_wrap_a: assert property (mode == tmr_pkg::MODE_NORMAL && tick_live && cnt_r == tmr_pkg::TOP_MAX
    |=> cnt_r == tmr_pkg::BOTTOM && overflow_flag_o)
    else $error("normal mode wrap or overflow wrong");
  ctc_clear_a: assert property (mode == tmr_pkg::MODE_CTC_CMP && tick_live && cnt_r == g_cmp[0].act_r
    |=> cnt_r == tmr_pkg::BOTTOM)
    else $error("clear-on-match did not clear");
  pc_turn_a: assert property (pc && tick_live && at_top && !dir_r && !at_bot
    |=> dir_r && cnt_r == $past(cnt_r) - 16'h0001 && g_cmp[0].act_r == $past(g_cmp[0].buf_r))
    else $error("phase correct turn at top wrong");
  fast_top_a: assert property (fast && tick_live && at_top
    |=> cnt_r == tmr_pkg::BOTTOM && overflow_flag_o && g_cmp[1].act_r == $past(g_cmp[1].buf_r))
    else $error("fast mode top handling wrong");
  pfc_bot_a: assert property (pfc && tick_live && at_bot && dir_r
    |=> overflow_flag_o && !dir_r && g_cmp[0].act_r == $past(g_cmp[0].buf_r))
    else $error("phase-frequency bottom handling wrong");
  cap_copy_a: assert property (cap_evt |=> capture_register_r == $past(cnt_r) && capture_flag_o)
    else $error("capture did not copy counter");
  cap_off_a: assert property (top_is_cap && !wr_cap
    |=> capture_register_r == $past(capture_register_r) && !$rose(capture_flag_o))
    else $error("capture active while used as top");
  stop_hold_a: assert property (cs == tmr_pkg::CS_STOP && !wr_cnt |=> $stable(cnt_r))
    else $error("stopped counter moved");
  pair_write_a: assert property (wr_cnt |=> cnt_r == {$past(temp_r), $past(io_req_i.wdata)})
    else $error("paired counter write wrong");
  wr_block_a: assert property (wr_cnt |=> ##1 compare_match_o == 2'h0)
    else $error("match not blocked after counter write");
  unmapped_a: assert property (io_req_i.rd && !(rd && mapped) |=> io_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  bit5_zero_a: assert property (io_req_i.rd && rd && ofs == tmr_pkg::OFS_CTRL_B |=> !io_rdata_o[5])
    else $error("control B bit five read as one");

  ovf_fast_c: cover property (fast && ovf_evt);
  cap_seen_c: cover property (cap_evt ##1 capture_flag_o);
  pc_turn_c:  cover property (pc && !dir_r ##1 dir_r);
endmodule

//--- sim/cpu_model.sv
// Purpose: CPU side of the I/O register bus, byte and byte-pair access
// Assumes: one request per transfer, launched just after a rising edge
// Notes:   a released bus shows inverted data so stale values never pass
module cpu_model (
  input  wire logic       mclk_i,
  input  wire logic [7:0] io_rdata_i,
  output tmr_pkg::io_req_t io_req_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial io_req_o = '0;
  task automatic xfer(input logic [5:0] ofs, input logic ds, input logic wr, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge mclk_i);
    io_req_o <= '{addr: {1'b0, ofs} + (ds ? tmr_pkg::DATA_BIAS : 7'h00), data_space: ds, wr: wr,
                  rd: !wr, wdata: d};
    @(posedge mclk_i);
    io_req_o.wr <= 1'b0;
    io_req_o.rd <= 1'b0;
    io_req_o.wdata <= ~d;
    @(negedge mclk_i);
    q = io_rdata_i;
  endtask
  task automatic wr16(input logic [5:0] lo, input logic [15:0] v);
    logic [7:0] q;
    xfer(lo + 6'h01, 1'b0, 1'b1, v[15:8], q);
    xfer(lo, 1'b0, 1'b1, v[7:0], q);
  endtask
  task automatic rd16(input logic [5:0] lo, output logic [15:0] v);
    xfer(lo, 1'b0, 1'b0, 8'h00, v[7:0]);
    xfer(lo + 6'h01, 1'b0, 1'b0, 8'h00, v[15:8]);
  endtask
endmodule

//--- sim/timer16_mode_clock_capture_tb.sv
// Purpose: self-checking bench for the timer mode, clock and capture block
// Assumes: counter runs from the bus clock; pins driven by the bench
// Notes:   prescaler phase is free, so divided counts are checked in a window
module timer16_mode_clock_capture_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic             mclk_i = 1'b0;
  logic             rst_i = 1'b1;
  logic             cap_pin = 1'b0;
  logic             ext_pin = 1'b0;
  logic             ovf_clr = 1'b0;
  logic             cap_clr = 1'b0;
  tmr_pkg::io_req_t io_req;
  logic [7:0]       io_rdata;
  logic [15:0]      cnt;
  logic             ovf;
  logic             capf;
  logic             down;
  logic [1:0]       match;
  int               num_errors = 0;
  int               num_checks = 0;
  int               nmatch = 0;
  always #25 mclk_i = ~mclk_i;
  timer16_mode_clock_capture u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .io_req_i(io_req),
    .capture_input_pin_i(cap_pin), .external_count_pin_i(ext_pin), .ovf_clear_i(ovf_clr),
    .cap_clear_i(cap_clr), .io_rdata_o(io_rdata), .counter_value_o(cnt), .overflow_flag_o(ovf),
    .capture_flag_o(capf), .compare_match_o(match), .count_down_o(down));
  cpu_model u_cpu (.mclk_i(mclk_i), .io_rdata_i(io_rdata), .io_req_o(io_req));
  always @(posedge mclk_i) nmatch <= nmatch + int'(match[0] === 1'b1) + int'(match[1] === 1'b1);
  task automatic test_done;
    if (num_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %0t %s got %h", $time, what, got);
    end
  endtask
  task automatic setm(input logic [3:0] m, input logic [7:0] b);
    logic [7:0] q;
    u_cpu.xfer(tmr_pkg::OFS_CTRL_A, 1'b0, 1'b1, {6'h00, m[1:0]}, q);
    u_cpu.xfer(tmr_pkg::OFS_CTRL_B, 1'b0, 1'b1, b | {3'h0, m[3:2], 3'h0}, q);
  endtask
  // Which: 0 overflow, 1 capture, 2 down; n is cycles waited
  task automatic waitfor(input int which, input int lim, output int n);
    for (n = 0; n < lim; n++) begin
      @(negedge mclk_i);
      if ((which == 0 ? ovf : which == 1 ? capf : down) === 1'b1) break;
    end
  endtask
  task automatic clr;
    @(posedge mclk_i);
    ovf_clr <= 1'b1;
    cap_clr <= 1'b1;
    @(posedge mclk_i);
    ovf_clr <= 1'b0;
    cap_clr <= 1'b0;
  endtask
  task automatic t_regs;
    logic [7:0] q;
    logic [15:0] v;
    u_cpu.xfer(tmr_pkg::OFS_CTRL_B, 1'b0, 1'b0, 8'h00, q);
    chk(q, tmr_pkg::CTRL_B_RST, "ctrl b reset");
    u_cpu.xfer(tmr_pkg::OFS_CTRL_B, 1'b1, 1'b1, 8'hff, q);
    u_cpu.xfer(tmr_pkg::OFS_CTRL_B, 1'b0, 1'b0, 8'h00, q);
    chk(q, 8'hdf, "ctrl b unused bit");
    u_cpu.xfer(6'h39, 1'b0, 1'b0, 8'h00, q);
    chk(q, 8'h00, "unmapped read");
    setm(tmr_pkg::MODE_NORMAL, 8'h00);
    u_cpu.wr16(tmr_pkg::OFS_CNT_LO, 16'ha55a);
    chk(cnt, 16'ha55a, "counter pair write");
    u_cpu.rd16(tmr_pkg::OFS_CNT_LO, v);
    chk(v, 16'ha55a, "counter pair read");
  endtask
  task automatic t_wrap(input logic [3:0] m, input logic [15:0] start);
    int n;
    setm(m, 8'h00);
    u_cpu.wr16(tmr_pkg::OFS_CNT_LO, start);
    clr();
    setm(m, {5'h00, tmr_pkg::CS_DIV1});
    waitfor(0, 40, n);
    chk(ovf, 1'b1, "overflow flag");
    chk(cnt < 16'h0003, 1'b1, "wrap to bottom");
  endtask
  task automatic t_ctc;
    setm(tmr_pkg::MODE_CTC_CMP, 8'h00);
    u_cpu.wr16(tmr_pkg::OFS_CMPA_LO, 16'h0020);
    u_cpu.wr16(tmr_pkg::OFS_CNT_LO, 16'h0010);
    clr();
    setm(tmr_pkg::MODE_CTC_CMP, {5'h00, tmr_pkg::CS_DIV1});
    repeat (40) @(negedge mclk_i);
    chk(cnt < 16'h0021, 1'b1, "clear at compare a");
    chk(ovf, 1'b0, "no flag below max");
  endtask
  task automatic t_dual(input logic [3:0] m, input logic [15:0] start);
    int n;
    setm(m, 8'h00);
    u_cpu.wr16(tmr_pkg::OFS_CNT_LO, start);
    clr();
    setm(m, {5'h00, tmr_pkg::CS_DIV1});
    waitfor(2, 40, n);
    chk(down, 1'b1, "down after top");
    chk(ovf, 1'b0, "no flag at top");
    waitfor(0, 600, n);
    chk(ovf, 1'b1, "flag raised");
    chk(cnt < 16'h0003, 1'b1, "flag at bottom");
  endtask
  task automatic cap_lat(input logic [7:0] b, input logic lvl, output int n);
    logic [7:0] q;
    u_cpu.xfer(tmr_pkg::OFS_CTRL_B, 1'b0, 1'b1, b, q);
    clr();
    @(posedge mclk_i);
    cap_pin <= lvl;
    waitfor(1, 30, n);
  endtask
  task automatic t_cap;
    int n0;
    int n1;
    logic [15:0] v;
    setm(tmr_pkg::MODE_NORMAL, 8'h00);
    u_cpu.wr16(tmr_pkg::OFS_CNT_LO, 16'h1234);
    cap_lat(8'h40, 1'b1, n0);
    chk(capf, 1'b1, "rising capture");
    u_cpu.rd16(tmr_pkg::OFS_CAP_LO, v);
    chk(v, 16'h1234, "capture value");
    cap_lat(8'h00, 1'b0, n0);
    chk(capf, 1'b1, "falling capture");
    cap_lat(8'h00, 1'b1, n1);
    chk(capf, 1'b0, "wrong edge ignored");
    cap_lat(8'h80, 1'b0, n1);
    chk(n1 - n0, 16'h0004, "filter delay");
    // Capture as top in the clear mode must mute the pin
    cap_lat(8'h58, 1'b1, n1);
    chk(capf, 1'b0, "capture disabled");
  endtask
  // Bench drives the pin as software would through an output
  task automatic t_ext(input logic [2:0] cs, input logic [15:0] exp_hi);
    setm(tmr_pkg::MODE_NORMAL, 8'h00);
    u_cpu.wr16(tmr_pkg::OFS_CNT_LO, 16'h0000);
    setm(tmr_pkg::MODE_NORMAL, {5'h00, cs});
    @(posedge mclk_i);
    ext_pin <= 1'b1;
    repeat (10) @(negedge mclk_i);
    chk(cnt, exp_hi, "after pin rise");
    @(posedge mclk_i);
    ext_pin <= 1'b0;
    repeat (10) @(negedge mclk_i);
    chk(cnt, 16'h0001, "after pin fall");
  endtask
  task automatic t_pre;
    int div [5] = '{1, 8, 64, 256, 1024};
    logic [15:0] v;
    for (int c = 1; c <= 5; c++) begin
      setm(tmr_pkg::MODE_NORMAL, 8'h00);
      u_cpu.wr16(tmr_pkg::OFS_CNT_LO, 16'h0000);
      setm(tmr_pkg::MODE_NORMAL, c[7:0]);
      repeat (4 * div[c-1]) @(negedge mclk_i);
      setm(tmr_pkg::MODE_NORMAL, 8'h00);
      chk(cnt >= 4 && cnt <= (c == 1 ? 10 : 5), 1'b1, "divided count");
    end
    v = cnt;
    repeat (20) @(negedge mclk_i);
    chk(cnt, v, "stopped counter");
  endtask
  task automatic t_sup;
    int m0;
    setm(tmr_pkg::MODE_NORMAL, 8'h00);
    u_cpu.wr16(tmr_pkg::OFS_CMPA_LO, 16'h0040);
    u_cpu.wr16(tmr_pkg::OFS_CMPB_LO, 16'h0040);
    setm(tmr_pkg::MODE_NORMAL, {5'h00, tmr_pkg::CS_DIV1});
    m0 = nmatch;
    u_cpu.wr16(tmr_pkg::OFS_CNT_LO, 16'h0040);
    repeat (4) @(negedge mclk_i);
    chk(nmatch == m0, 1'b1, "match blocked after write");
    m0 = nmatch;
    u_cpu.wr16(tmr_pkg::OFS_CNT_LO, 16'h003e);
    repeat (6) @(negedge mclk_i);
    chk(nmatch == m0 + 2, 1'b1, "immediate compare match");
  endtask
  task automatic t_rsv;
    logic [15:0] v;
    setm(tmr_pkg::MODE_RSVD, {5'h00, tmr_pkg::CS_DIV1});
    v = cnt;
    repeat (10) @(negedge mclk_i);
    chk(cnt, v, "reserved mode holds");
  endtask
  initial begin
    repeat (8) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(negedge mclk_i);
    chk(cnt, tmr_pkg::REG16_RST, "counter reset");
    t_regs();
    t_wrap(tmr_pkg::MODE_NORMAL, 16'hfff0);
    t_wrap(tmr_pkg::MODE_FAST8, 16'h00f0);
    t_wrap(tmr_pkg::MODE_FAST9, 16'h01f0);
    t_wrap(tmr_pkg::MODE_FAST10, 16'h03f0);
    t_ctc();
    // Compare A holds 0x0020 from here until t_sup, so it serves as TOP
    t_wrap(tmr_pkg::MODE_FAST_CMP, 16'h0010);
    t_dual(tmr_pkg::MODE_PC8, 16'h00f0);
    t_dual(tmr_pkg::MODE_PC9, 16'h01f0);
    t_dual(tmr_pkg::MODE_PC_CMP, 16'h0010);
    t_dual(tmr_pkg::MODE_PFC_CMP, 16'h0010);
    t_rsv();
    t_cap();
    // Capture register now holds 0x1234 and serves as TOP
    t_wrap(tmr_pkg::MODE_FAST_CAP, 16'h1224);
    t_ext(tmr_pkg::CS_EXT_RISE, 16'h0001);
    t_ext(tmr_pkg::CS_EXT_FALL, 16'h0000);
    t_pre();
    t_sup();
    test_done();
  end
  // Whole run is under ten thousand cycles; this leaves ample margin
  initial begin
    #2000000;
    num_errors++;
    test_done();
  end
endmodule
